/* dv/serial_word_output_decoder_tb.sv */
// Self-checking bench for the serial word output decoder.
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin checks = checks + 1; \
    if ((ex) !== (got)) begin fail_count = fail_count + 1; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module serial_word_output_decoder_tb;
    localparam DELAY = 20;  // Short relay delay keeps the run brief.
    logic        aclk = 0, aresetn = 0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, seed = 32'h3c;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    wire         serial_line, bit_clock, s_axi_awready, s_axi_wready;
    wire         s_axi_bvalid, s_axi_arready, s_axi_rvalid, strobe;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    wire [2:0]   led_first, led_second, scan_forward, scan_reverse;
    wire [2:0]   direct;   // Line 1 relay A, line 1 relay B, ring relay.
    wire [4:0]   delayed;  // Hold, line 2 A, line 2 B, line 3 A, line 3 B.
    integer      fail_count = 0, checks = 0, cycles = 0, i;
    integer      seen_first = 0, seen_second = 0;
    logic [22:0] word_q[$], a, b, m;  // Strobed words awaiting checks.
    logic [1:0]  wr_q[$], ew;         // Expected write responses.
    logic [33:0] rd_q[$], er;         // Expected read response and data.
    always #2 aclk = ~aclk;
    serial_word_output_decoder #(.RELAY_DELAY_CYC(DELAY)) uut (
        .aclk(aclk), .aresetn(aresetn), .serial_line(serial_line),
        .bit_clock(bit_clock), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .led_first(led_first), .led_second(led_second),
        .line1_relay_a(direct[2]), .line1_relay_b(direct[1]),
        .ring_relay(direct[0]), .hold_relay(delayed[4]),
        .line2_relay_a(delayed[3]), .line2_relay_b(delayed[2]),
        .line3_relay_a(delayed[1]), .line3_relay_b(delayed[0]),
        .scan_forward(scan_forward), .scan_reverse(scan_reverse),
        .strobe(strobe));
    word_controller_model ctl (.aclk(aclk), .serial_line(serial_line),
        .bit_clock(bit_clock));

    function [31:0] xs(input [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction
    // Write master: releases each channel at the edge it is taken.
    task axi_write(input [7:0] ad, input [31:0] d, input [1:0] r);
        begin
            @(posedge aclk);
            s_axi_awaddr <= ad;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            wr_q.push_back(r);
            do begin
                @(posedge aclk);
                if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            end while (s_axi_bvalid !== 1'b1);
            s_axi_bready <= 1'b0;
        end
    endtask

    // Read master: the expected answer is noted before the request.
    task axi_read(input [7:0] ad, input [33:0] e);
        begin
            @(posedge aclk);
            s_axi_araddr <= ad;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            rd_q.push_back(e);
            do begin
                @(posedge aclk);
                if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            end while (s_axi_rvalid !== 1'b1);
            s_axi_rready <= 1'b0;
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", checks, fail_count);
            if (fail_count == 0 && checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Cuts a hang short and notes which LED mux phases were seen.
    always @(posedge aclk) begin
        cycles = cycles + 1;
        if (led_first === 3'h7) seen_first = seen_first + 1;
        if (led_second === 3'h7) seen_second = seen_second + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            give_verdict;
        end
    end

    // Bus answers are compared with the oldest noted expectation.
    initial forever begin
        @(posedge aclk);
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            ew = wr_q.pop_front();
            `CHECK("write response", ew, s_axi_bresp)
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            er = rd_q.pop_front();
            `CHECK("read answer", er, {s_axi_rresp, s_axi_rdata})
        end
    end

    // Each strobe is matched to a noted word once the outputs settle.
    initial forever begin
        @(posedge aclk);
        if (strobe === 1'b1) begin
            repeat (4) @(posedge aclk);
            m = word_q.pop_front();
            `CHECK("direct relays", {m[12], m[13], m[15]}, direct)
            `CHECK("fwd scan", m[16] ? m[22:20] : 3'h0, scan_forward)
            `CHECK("rev scan", m[16] ? 3'h0 : m[22:20], scan_reverse)
            `CHECK("led first", 3'h0, led_first & ~{m[4], m[2], m[0]})
            `CHECK("led second", 3'h0, led_second & ~{m[5], m[3], m[1]})
        end
    end

    // Main sequence: registers, then word pairs, then LED multiplexing.
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHECK("reset leds", 6'h0, {led_first, led_second})
        `CHECK("reset scans", 6'h0, {scan_forward, scan_reverse})
        `CHECK("reset relays", 9'h0, {direct, delayed, strobe})
        axi_read(8'h00, {2'b00, 32'h00000001});
        axi_write(8'h04, 32'h000000ff, 2'b00);
        axi_write(8'h00, 32'h00000001, 2'b00);
        axi_write(8'h20, 32'h00000000, 2'b10);
        axi_read(8'h20, {2'b10, 32'h00000000});
        for (i = 0; i < 8; i++) begin
            seed = xs(seed);
            a = seed[22:0];
            a[22:20] = (i % 4 == 0) ? 3'h0 : 3'h1 << (i % 4 - 1);
            a[16] = i[2];
            seed = xs(seed);
            b = seed[22:0];
            b[22:20] = 3'h0;
            word_q.push_back(a);
            ctl.send_word(a, 1'b1);
            ctl.send_word(b, 1'b0);
            `CHECK("delayed relays", {a[14], a[11:8]}, delayed)
            axi_read(8'h08, {2'b00, 9'h000, a});
            axi_read(8'h0c, {2'b00, 9'h000, b});
        end
        for (i = 0; i < 12; i++) begin
            word_q.push_back(23'h00003f);
            ctl.send_word(23'h00003f, 1'b1);
        end
        // The strobe checker takes its word four edges after the strobe.
        repeat (8) @(posedge aclk);
        axi_read(8'h10, {2'b00, 32'h00000014});
        `CHECK("mux phases", 1'b1, seen_first > 0 && seen_second > 0)
        `CHECK("words left", 0, word_q.size())
        give_verdict;
    end
endmodule

/* dv/word_controller_model.sv */
// Behavioural model of the call controller sending serial words.
`timescale 1ns/1ps
module word_controller_model (
    input  wire  aclk,         // System clock.
    output logic serial_line,  // Serial data to the decoder.
    output logic bit_clock     // Bit clock, still between frames.
);
    initial begin
        serial_line = 1'b0;
        bit_clock   = 1'b0;
    end

    // Sends bit 1 first, then bit 24, then the gap slot carrying sync.
    // The bit clock is sped up so a word takes 200 cycles, not 1 ms.
    task automatic send_word(input logic [22:0] w, input logic sync);
        logic [24:0] f;
        integer      i;
        begin
            f = {sync, 1'b0, w};
            for (i = 0; i < 25; i++) begin
                @(posedge aclk);
                serial_line <= f[i];
                bit_clock   <= 1'b0;
                repeat (4) @(posedge aclk);
                bit_clock   <= 1'b1;
                repeat (3) @(posedge aclk);
            end
            @(posedge aclk);
            bit_clock   <= 1'b0;
            // A released line must not keep showing the last value.
            serial_line <= ~f[24];
        end
    endtask
endmodule

/* dv/word_decoder_props.sv */
// Port-level assertions for the serial word output decoder.
`timescale 1ns/1ps
module word_decoder_props #(
    parameter RELAY_DELAY_CYC = 20  // Relay delay length.
) (
    input wire       aclk,           // Clock.
    input wire       aresetn,        // Reset, active low.
    input wire       strobe,         // Read strobe.
    input wire       line1_relay_a,  // Direct relay.
    input wire       hold_relay,     // Delayed relay.
    input wire [2:0] scan_forward,   // Forward scan.
    input wire [2:0] scan_reverse,   // Reverse scan.
    input wire [2:0] led_first,      // First LED drive.
    input wire [2:0] led_second,     // Second LED drive.
    input wire       s_axi_awvalid,  // Write address valid.
    input wire       s_axi_wvalid,   // Write data valid.
    input wire       s_axi_bvalid,   // Write response valid.
    input wire       s_axi_bready,   // Write response ready.
    input wire       s_axi_arvalid,  // Read address valid.
    input wire       s_axi_arready,  // Read address ready.
    input wire       s_axi_rvalid    // Read data valid.
);
    // ****************************************************************
    // Helper counter
    // ****************************************************************
    reg [15:0] since_strobe;  // Cycles since the last strobe, saturating.

    // Counts cycles since a strobe; a delayed relay may only move late.
    always @(posedge aclk) begin
        if (!aresetn || strobe) begin
            since_strobe <= 16'h0000;
        end else if (since_strobe != 16'hffff) begin
            since_strobe <= since_strobe + 16'h0001;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    chk_strobe_single: assert property (strobe |=> !strobe)
        else $error("strobe lasted more than one cycle");
    chk_direct_timing: assert property ($changed(line1_relay_a) |->
        $past(strobe, 2) || $past(strobe, 3))
        else $error("direct relay moved without a strobe");
    chk_scan_timing: assert property ($changed(scan_forward) ||
        $changed(scan_reverse) |-> $past(strobe, 2) || $past(strobe, 3))
        else $error("scan outputs moved without a strobe");
    chk_scan_exclusive: assert property ((scan_forward & scan_reverse)
        == 3'h0) else $error("forward and reverse scan together");
    chk_led_alternate: assert property ((led_first & led_second)
        == 3'h0) else $error("both LED drives of a terminal high");
    chk_hold_delay: assert property ($changed(hold_relay) |->
        since_strobe >= RELAY_DELAY_CYC - 4)
        else $error("hold relay moved too soon after a strobe");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_wvalid &&
        !s_axi_bvalid |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write response dropped early");
    chk_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid
        |=> s_axi_rvalid && s_axi_arready) else $error("read answer late");

    cov_strobe: cover property (strobe);
    cov_hold_on: cover property ($rose(hold_relay));
    cov_read: cover property (s_axi_rvalid && s_axi_arready);
endmodule

bind serial_word_output_decoder word_decoder_props #(
    .RELAY_DELAY_CYC(RELAY_DELAY_CYC)
) props_i (
    .aclk(aclk), .aresetn(aresetn), .strobe(strobe),
    .line1_relay_a(line1_relay_a), .hold_relay(hold_relay),
    .scan_forward(scan_forward), .scan_reverse(scan_reverse),
    .led_first(led_first), .led_second(led_second),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid)
);

/* hw/relay_delay.v */
// Delay stage for relay bits: output follows input after a settle time.
`timescale 1ns/1ps
module relay_delay #(
    parameter DELAY_CYC = 1000000  // Cycles the input must stay changed.
) (
    input  wire aclk,     // System clock.
    input  wire aresetn,  // Synchronous reset, active low.
    input  wire d,        // Undelayed relay bit.
    output reg  q         // Delayed relay bit.
);
    // ************************************************************
    // Settle counter
    // ************************************************************
    reg [31:0] count;  // Cycles since input first differed from q.

    // A glitchy change shorter than the delay never reaches the relay,
    // which is what keeps clicks off the exchange line.
    always @(posedge aclk) begin
        if (!aresetn) begin
            count <= 32'h0;
            q     <= 1'b0;
        end else if (d == q) begin
            count <= 32'h0;
        end else if (count >= DELAY_CYC - 1) begin
            count <= 32'h0;
            q     <= d;
        end else begin
            count <= count + 32'h1;
        end
    end
endmodule

/* hw/serial_word_output_decoder.v */
// Serial control word decoder with LED, relay and scan outputs.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "word_decoder_regs.vh"
module serial_word_output_decoder #(
    parameter RELAY_DELAY_CYC = `RELAY_DELAY_CYC  // Relay delay length.
) (
    input  wire        aclk,           // System clock, 250 MHz.
    input  wire        aresetn,        // Synchronous reset, active low.
    input  wire        serial_line,    // Serial data line from controller.
    input  wire        bit_clock,      // 24 kHz link clock, sampled.
    input  wire [7:0]  s_axi_awaddr,   // Write address.
    input  wire        s_axi_awvalid,  // Write address valid.
    output reg         s_axi_awready,  // Write address ready.
    input  wire [31:0] s_axi_wdata,    // Write data.
    input  wire [3:0]  s_axi_wstrb,    // Write byte strobes.
    input  wire        s_axi_wvalid,   // Write data valid.
    output reg         s_axi_wready,   // Write data ready.
    output reg  [1:0]  s_axi_bresp,    // Write response.
    output reg         s_axi_bvalid,   // Write response valid.
    input  wire        s_axi_bready,   // Write response ready.
    input  wire [7:0]  s_axi_araddr,   // Read address.
    input  wire        s_axi_arvalid,  // Read address valid.
    output reg         s_axi_arready,  // Read address ready.
    output reg  [31:0] s_axi_rdata,    // Read data.
    output reg  [1:0]  s_axi_rresp,    // Read response.
    output reg         s_axi_rvalid,   // Read data valid.
    input  wire        s_axi_rready,   // Read data ready.
    output reg  [2:0]  led_first,      // First LED signal per terminal.
    output reg  [2:0]  led_second,     // Second LED signal per terminal.
    output reg         line1_relay_a,  // Line 1 relay A, bit 13.
    output reg         line1_relay_b,  // Line 1 relay B, bit 14.
    output reg         ring_relay,     // Ring relay, bit 16.
    output reg         hold_relay,     // Hold relay, bit 15, delayed.
    output reg         line2_relay_a,  // Line 2 relay A, bit 12, delayed.
    output reg         line2_relay_b,  // Line 2 relay B, bit 11, delayed.
    output reg         line3_relay_a,  // Line 3 relay A, bit 10, delayed.
    output reg         line3_relay_b,  // Line 3 relay B, bit 9, delayed.
    output reg  [2:0]  scan_forward,   // Forward scan per terminal.
    output reg  [2:0]  scan_reverse,   // Reverse scan per terminal.
    output reg         strobe          // One-cycle read strobe pulse.
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    reg [1:0] data_sync;   // Two-stage synchroniser for the data line.
    reg [1:0] clk_sync;    // Two-stage synchroniser for the bit clock.
    reg       clk_prev;    // Previous synchronised bit clock.

    // Both pins come from outside the clock domain.
    always @(posedge aclk) begin
        if (!aresetn) begin
            data_sync <= 2'b00;
            clk_sync  <= 2'b00;
            clk_prev  <= 1'b0;
        end else begin
            data_sync <= {data_sync[0], serial_line};
            clk_sync  <= {clk_sync[0], bit_clock};
            clk_prev  <= clk_sync[1];
        end
    end

    wire data_in  = data_sync[1];             // Clean data level.
    wire bit_tick = clk_sync[1] & ~clk_prev;  // One pulse per bit period.

    // ************************************************************
    // Word shifter and strobe extractor
    // ************************************************************
    reg        enable;       // Software enable of the decoder.
    reg [4:0]  bit_count;    // Slot number within the word, 0 to 24.
    reg [22:0] shift_reg;    // Leading 23 bits of the current word.
    reg [22:0] latch;        // Strobed word held for the outputs.
    reg        saw_bit24;    // The 24th bit has been passed.
    reg [15:0] strobe_count; // Strobes seen, for software.
    reg [2:0]  timer_count;  // Strobe counter of the 10 ms timer.
    reg        mux_phase;    // Divide-by-two of the timer, 50 Hz.

    // Slot 0..22 are data, slot 23 is the 24th bit, slot 24 is the gap.
    // The word boundary is taken from the bit count alone; framing is
    // held by the continuous stream, so a lost bit realigns only after
    // the next reset or disable.
    always @(posedge aclk) begin
        if (!aresetn || !enable) begin
            bit_count <= 5'd0;
            shift_reg <= 23'h0;
            saw_bit24 <= 1'b0;
            strobe    <= 1'b0;
        end else begin
            strobe <= 1'b0;
            if (bit_tick) begin
                if (bit_count < 5'd23) begin
                    shift_reg <= {data_in, shift_reg[22:1]};
                    bit_count <= bit_count + 5'd1;
                end else if (bit_count == 5'd23) begin
                    saw_bit24 <= 1'b1;
                    bit_count <= 5'd24;
                end else begin
                    // Gap slot: active level marks this word as ours.
                    strobe    <= saw_bit24 & data_in;
                    saw_bit24 <= 1'b0;
                    bit_count <= 5'd0;
                end
            end
        end
    end

    // Latches follow the strobe only; otherwise they hold.
    always @(posedge aclk) begin
        if (!aresetn) begin
            latch <= 23'h0;
        end else if (strobe) begin
            latch <= shift_reg;
        end else begin
            latch <= latch;
        end
    end

    // ************************************************************
    // 10 ms timer clocked by the strobe
    // ************************************************************
    // Five 2 ms strobes make 10 ms; the toggle gives 50 Hz.
    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_count  <= 3'd0;
            mux_phase    <= 1'b0;
            strobe_count <= 16'h0;
        end else if (strobe) begin
            strobe_count <= strobe_count + 16'h1;
            if (timer_count == `TIMER_STROBES - 1) begin
                timer_count <= 3'd0;
                mux_phase   <= ~mux_phase;
            end else begin
                timer_count <= timer_count + 3'd1;
            end
        end
    end

    // Picks word bit n (1-based) from the latch.
    function field;
        input [22:0] w;
        input integer n;
        begin
            field = w[n-1];
        end
    endfunction

    // ************************************************************
    // Relay delay stages
    // ************************************************************
    wire [4:0] delay_in;   // Undelayed bits 9, 10, 11, 12, 15.
    wire [4:0] delay_out;  // Delayed versions.
    assign delay_in = {field(latch, `BIT_HOLD),
                       field(latch, `BIT_L2_RELAY_A),
                       field(latch, `BIT_L2_RELAY_B),
                       field(latch, `BIT_L3_RELAY_A),
                       field(latch, `BIT_L3_RELAY_B)};

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : gen_delay
            relay_delay #(
                .DELAY_CYC (RELAY_DELAY_CYC)
            ) u_delay (
                .aclk    (aclk),
                .aresetn (aresetn),
                .d       (delay_in[g]),
                .q       (delay_out[g])
            );
        end
    endgenerate

    // ************************************************************
    // Output registers
    // ************************************************************
    wire [2:0] term_sel = {field(latch, `BIT_SCAN_T3),
                           field(latch, `BIT_SCAN_T2),
                           field(latch, `BIT_SCAN_T1)};  // Terminal pick.
    wire       fwd      = field(latch, `BIT_SCAN_FWD);   // Scan direction.

    // LED bits sit in the low six bits of the word, two per terminal.
    // While disabled the LEDs and scans go dark but relays keep state,
    // so software cannot drop a call by toggling the enable.
    always @(posedge aclk) begin
        if (!aresetn) begin
            led_first     <= 3'b000;
            led_second    <= 3'b000;
            line1_relay_a <= 1'b0;
            line1_relay_b <= 1'b0;
            ring_relay    <= 1'b0;
            hold_relay    <= 1'b0;
            line2_relay_a <= 1'b0;
            line2_relay_b <= 1'b0;
            line3_relay_a <= 1'b0;
            line3_relay_b <= 1'b0;
            scan_forward  <= 3'b000;
            scan_reverse  <= 3'b000;
        end else begin
            // Only one of each pair is driven at a time.
            led_first  <= (enable & ~mux_phase) ?
                          {latch[4], latch[2], latch[0]} : 3'b000;
            led_second <= (enable & mux_phase) ?
                          {latch[5], latch[3], latch[1]} : 3'b000;
            line1_relay_a <= field(latch, `BIT_L1_RELAY_A);
            line1_relay_b <= field(latch, `BIT_L1_RELAY_B);
            ring_relay    <= field(latch, `BIT_RING);
            line3_relay_b <= delay_out[0];
            line3_relay_a <= delay_out[1];
            line2_relay_b <= delay_out[2];
            line2_relay_a <= delay_out[3];
            hold_relay    <= delay_out[4];
            // No terminal bit means no scan signal at all.
            scan_forward <= enable ? (term_sel & {3{fwd}}) : 3'b000;
            scan_reverse <= enable ? (term_sel & {3{~fwd}}) : 3'b000;
        end
    end

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    reg [7:0] wr_addr;   // Captured write address.
    reg       have_aw;   // Write address taken.
    reg       have_w;    // Write data taken.
    reg [31:0] wr_data;  // Captured write data.
    reg [3:0]  wr_strb;  // Captured write strobes.

    // Address and data are taken independently; the response follows
    // once both are in, and a new write waits for bready.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_OKAY;
            have_aw       <= 1'b0;
            have_w        <= 1'b0;
            wr_addr       <= 8'h00;
            wr_data       <= 32'h0;
            wr_strb       <= 4'h0;
            enable        <= 1'b1;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !have_aw && !s_axi_awready &&
                !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                have_aw       <= 1'b1;
                wr_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !have_w && !s_axi_wready &&
                !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
                have_w       <= 1'b1;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
            end
            if (have_aw && have_w && !s_axi_bvalid) begin
                have_aw      <= 1'b0;
                have_w       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_addr == `REG_CONTROL) begin
                    s_axi_bresp <= `AXI_OKAY;
                    if (wr_strb[0]) begin
                        enable <= wr_data[0];
                    end
                end else if (wr_addr == `REG_STATUS ||
                             wr_addr == `REG_LATCH  ||
                             wr_addr == `REG_SHIFT  ||
                             wr_addr == `REG_STROBES) begin
                    s_axi_bresp <= `AXI_OKAY;  // Read-only, write ignored.
                end else begin
                    s_axi_bresp <= `AXI_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Reads answer in the same cycle the address is taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `AXI_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `AXI_OKAY;
                case (s_axi_araddr)
                    `REG_CONTROL: s_axi_rdata <= {31'h0, enable};
                    `REG_STATUS:  s_axi_rdata <= {26'h0, timer_count,
                                                  mux_phase, saw_bit24,
                                                  enable};
                    `REG_LATCH:   s_axi_rdata <= {9'h0, latch};
                    `REG_SHIFT:   s_axi_rdata <= {9'h0, shift_reg};
                    `REG_STROBES: s_axi_rdata <= {16'h0, strobe_count};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `AXI_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

/* hw/word_decoder_regs.vh */
// Constants of the serial word output decoder and its register map.
`ifndef WORD_DECODER_REGS_VH
`define WORD_DECODER_REGS_VH
// ****************************************************************
// Link timing
// ****************************************************************
`define CLK_HZ          250000000
`define BAUD_HZ         24000
`define BIT_CYCLES      (`CLK_HZ / `BAUD_HZ)
`define WORD_BITS       24
`define SHIFT_BITS      23
// ****************************************************************
// Word field positions, bits counted from 1 as transmitted
// ****************************************************************
`define BIT_L3_RELAY_B  9
`define BIT_L3_RELAY_A  10
`define BIT_L2_RELAY_B  11
`define BIT_L2_RELAY_A  12
`define BIT_L1_RELAY_A  13
`define BIT_L1_RELAY_B  14
`define BIT_HOLD        15
`define BIT_RING        16
`define BIT_SCAN_FWD    17
`define BIT_SCAN_T1     21
`define BIT_SCAN_T2     22
`define BIT_SCAN_T3     23
// ****************************************************************
// Timer and delay
// ****************************************************************
`define TIMER_STROBES   5
`define RELAY_DELAY_MS  4
`define RELAY_DELAY_CYC (`RELAY_DELAY_MS * (`CLK_HZ / 1000))
// ****************************************************************
// AXI4-Lite register map
// ****************************************************************
`define REG_CONTROL     8'h00
`define REG_STATUS      8'h04
`define REG_LATCH       8'h08
`define REG_SHIFT       8'h0c
`define REG_STROBES     8'h10
`define CONTROL_RESET   32'h00000001
`define AXI_OKAY        2'b00
`define AXI_SLVERR      2'b10
`endif
